// >>> dcbi_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: A 100 MHz clock; all times are in nanoseconds.
// Notes:   Definitions only; included by bare name.
`ifndef DCBI_DEFS_SVH
`define DCBI_DEFS_SVH
// ****************************************
// Timing
// ****************************************
`define DCBI_CLK_NS        10
`define DCBI_ADDR_NS       20
`define DCBI_ADDR_CYC      ((`DCBI_ADDR_NS + `DCBI_CLK_NS - 1) / `DCBI_CLK_NS)
`define DCBI_STRB_NS       30
`define DCBI_STRB_CYC      ((`DCBI_STRB_NS + `DCBI_CLK_NS - 1) / `DCBI_CLK_NS)
`define DCBI_POR_NS        5000
`define DCBI_POR_CYC       ((`DCBI_POR_NS + `DCBI_CLK_NS - 1) / `DCBI_CLK_NS)
`define DCBI_UCYC_NS       2000
`define DCBI_INIT_MIN_UCYC 4
`define DCBI_INIT_MIN_CYC  ((`DCBI_INIT_MIN_UCYC * `DCBI_UCYC_NS) / `DCBI_CLK_NS)
`define DCBI_CNT_W         10
// ****************************************
// Address map
// ****************************************
`define DCBI_RSV_LO        16'h7000
`define DCBI_RSV_HI        16'h7FFF
`define DCBI_SAVE_LO       16'h77F5
`define DCBI_SAVE_HI       16'h77FF
`define DCBI_SAVE_N        11
`define DCBI_SAVE_PC       16'h77F5
`define DCBI_SAVE_P1       16'h77F7
`define DCBI_SAVE_P2       16'h77F9
`define DCBI_SAVE_P3       16'h77FB
`define DCBI_SAVE_AC       16'h77FD
`define DCBI_SAVE_EX       16'h77FE
`define DCBI_SAVE_SR       16'h77FF
`define DCBI_REG_CTRL      16'h77F0
`define DCBI_REG_LDLO      16'h77F1
`define DCBI_REG_LDHI      16'h77F2
`define DCBI_REG_LDDAT     16'h77F3
`define DCBI_REG_STAT      16'h77F4
// ****************************************
// Fields and reset values
// ****************************************
`define DCBI_CTRL_GO       0
`define DCBI_CTRL_CLR      1
`define DCBI_STAT_DBG      0
`define DCBI_STAT_LDBUSY   1
`define DCBI_STAT_RSVHIT   2
`define DCBI_STAT_INIT     3
`define DCBI_PIN_RST       4'b0111
`endif

// >>> dcbi_pkg.sv
// Purpose: Types shared by the bus interface files.
// Assumes: Nothing beyond the constants header.
// Notes:   Constants live in dcbi_defs.svh.
package dcbi_pkg;
	// One processor bus cycle as the core asks for it.
	typedef struct packed {
		logic [15:0] addr;   // Full 16-bit address.
		logic [7:0]  wdata;  // Byte to write.
		logic        read;   // High for an input cycle.
		logic        opcode_fetch_flag; // First opcode byte.
		logic        delay;  // Delay cycle status.
		logic        halt;   // Halt status.
	} dcbi_cyc_t;
	// Bus cycle sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_INT,
		ST_DONE
	} dcbi_state_t;
endpackage

// >>> dcbi_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Bits are independent levels.
// Notes:   The first flop feeds only the second.
`timescale 1ns/1ps
module dcbi_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,   // Clock.
	input  wire logic         rst_n, // Reset, active low.
	input  wire logic [W-1:0] d,     // Asynchronous input.
	output logic      [W-1:0] q      // Synchronised copy.
);
	// ****************************************
	// Per-bit flop pair
	// ****************************************
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		logic meta_q; // Only the second flop reads this.
		// Reset value is a constant chosen per bit.
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q <= INIT[i];
				q[i]   <= INIT[i];
			end else begin
				meta_q <= d[i];
				q[i]   <= meta_q;
			end
		end
	end
endmodule

// >>> dcbi_state_mem.sv
// Purpose: Saved processor state bytes with registered read.
// Assumes: One write and one read port, same clock.
// Notes:   Contents are not reset; software restores them.
`timescale 1ns/1ps
`include "dcbi_defs.svh"
module dcbi_state_mem import dcbi_pkg::*; (
	input  wire logic       clk,     // Clock.
	input  wire logic       wr_en,   // Write this cycle.
	input  wire logic [3:0] wr_idx,  // Write index.
	input  wire logic [7:0] wr_data, // Write byte.
	input  wire logic [3:0] rd_idx,  // Read index.
	output logic      [7:0] rd_data  // Read byte, one cycle later.
);
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] mem_q [`DCBI_SAVE_N]; // Eleven saved bytes.
	// Out-of-range indices are dropped on write and read as zero.
	always_ff @(posedge clk) begin
		if (wr_en && wr_idx < 4'(`DCBI_SAVE_N)) begin
			mem_q[wr_idx] <= wr_data;
		end
		rd_data <= (rd_idx < 4'(`DCBI_SAVE_N)) ? mem_q[rd_idx] : 8'h00;
	end
endmodule

// >>> dcbi_top.sv
// Purpose: Processor card bus interface with RUN and DEBUG serving.
// Assumes: Pins are asynchronous and pass two flops; 100 MHz clock.
// Notes:   The board supplies the pull-ups and resolves open-drain pins.
`timescale 1ns/1ps
`include "dcbi_defs.svh"
// What this block does
// - Range 7000-7FFF is kept for debug use
// - RUN serves application, DEBUG serves development memory
// - Saved state sits at 77F5 to 77FF
// - Saved PC and AC are writable bytes
// - Loaded bytes go contiguous and unmodified
// - Low wait line stretches the data strobe
// - Wait line idles high, no stretch
// - Power-on drives init pulse, enters DEBUG
// - Reinit during RUN forces DEBUG mode
// - Reinit during DEBUG aborts work in progress
// - Drive enable high drives address lines
// - Drive enable low floats address lines
// - Data lines float outside the three strobes
// - Address strobe carries upper address and status
// - Data strobe moves one byte
// - Data lines 0-3 carry address 12-15
// - Data lines 4-7 carry read, fetch, delay and halt status
// - Cycle request high until cycle completes
module dcbi_top import dcbi_pkg::*; (
	input  wire logic        clk,                  // 100 MHz clock.
	input  wire logic        rst_n,                // Async reset, active low.
	input  wire logic        core_req,             // Core wants a cycle.
	input  wire dcbi_cyc_t   core_cyc,             // Cycle held with request.
	output logic             core_done,            // Cycle finished pulse.
	output logic      [7:0]  core_rdata,           // Read byte at done.
	output logic             core_init,            // Hold core in init.
	output logic             debug_entry,          // Restart at debug entry.
	input  wire logic [15:0] reg_addr,             // Register address.
	input  wire logic [7:0]  reg_wdata,            // Register write data.
	input  wire logic        reg_wr,               // Write strobe.
	input  wire logic        reg_rd,               // Read strobe.
	output logic      [7:0]  reg_rdata,            // Read data, next cycle.
	output logic      [15:0] address_lines_o,      // Address out.
	output logic             address_lines_oe,     // Address drive.
	input  wire logic        address_drive_enable, // Address enable pin.
	output logic             address_strobe_n,     // Address strobe.
	output logic             read_strobe_n,        // Read strobe.
	output logic             write_strobe_n,       // Write strobe.
	input  wire logic [7:0]  shared_data_lines_i,  // Data in.
	output logic      [7:0]  shared_data_lines_o,  // Data out.
	output logic             shared_data_lines_oe, // Data drive.
	input  wire logic        memory_wait_line,     // Wait, low stretches.
	input  wire logic        init_line_n_i,        // Init line level.
	output logic             init_line_n_o,        // Init drive value.
	output logic             init_line_n_oe,       // Init pull-down.
	output logic             cycle_request_out,    // Bus request.
	input  wire logic        halt_stop_select,     // Halt enters DEBUG.
	output logic             debug_mode            // High in DEBUG mode.
);
	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic       rs1_q;   // First reset release flop.
	logic       rs2_q;   // Released reset used everywhere.
	logic       rst_s_n; // Synchronised reset.
	logic [3:0] pins_s;  // Synchronised control pins.
	logic [7:0] data_s;  // Synchronised data lines.
	logic       aden_s;  // Address enable.
	logic       wait_s;  // Wait line, high when idle.
	logic       init_s;  // Init line level.
	logic       hsel_s;  // Halt select.
	// Reset asserts at once and releases after two edges.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	assign rst_s_n = rs2_q;
	// The wait flops reset high, so no stretch until driven low.
	dcbi_sync #(.W(4), .INIT(`DCBI_PIN_RST)) u_pins (
		.clk   (clk),
		.rst_n (rst_s_n),
		.d     ({halt_stop_select, init_line_n_i, memory_wait_line,
		         address_drive_enable}),
		.q     (pins_s)
	);
	// Read data lag two clocks; responders hold them to strobe end.
	dcbi_sync #(.W(8), .INIT(8'h00)) u_data (
		.clk   (clk),
		.rst_n (rst_s_n),
		.d     (shared_data_lines_i),
		.q     (data_s)
	);
	assign aden_s = pins_s[0];
	assign wait_s = pins_s[1];
	assign init_s = pins_s[2];
	assign hsel_s = pins_s[3];
	// ****************************************
	// Power-on pulse and re-initialisation
	// ****************************************
	logic                  por_q;      // Power-on pulse active.
	logic [`DCBI_CNT_W-1:0] por_cnt_q;  // Power-on pulse length.
	logic [`DCBI_CNT_W-1:0] ilow_cnt_q; // Cycles init seen low.
	logic                  por_end;    // Last cycle of pulse.
	logic                  ilow_sat;   // Low long enough.
	logic                  reinit;     // External reinit event.
	logic                  dbg_ent_q;  // Debug entry pulse.
	assign por_end  = por_q && por_cnt_q == `DCBI_CNT_W'(`DCBI_POR_CYC - 1);
	assign ilow_sat = ilow_cnt_q == `DCBI_CNT_W'(`DCBI_INIT_MIN_CYC);
	// Short glitches below four microcycles are ignored.
	assign reinit   = !por_q && !init_s &&
	                  ilow_cnt_q == `DCBI_CNT_W'(`DCBI_INIT_MIN_CYC - 1);
	// Our own pulse is not sensed, so it cannot retrigger itself.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			por_q     <= 1'b1;
			por_cnt_q <= '0;
		end else if (por_q) begin
			por_q     <= !por_end;
			por_cnt_q <= por_cnt_q + `DCBI_CNT_W'(1);
		end
	end
	// Count low time, saturating so one event fires per low period.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ilow_cnt_q <= '0;
		end else if (por_q || init_s) begin
			ilow_cnt_q <= '0;
		end else if (!ilow_sat) begin
			ilow_cnt_q <= ilow_cnt_q + `DCBI_CNT_W'(1);
		end
	end
	// Either kind of init restarts the core at its debug entry.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			dbg_ent_q <= 1'b0;
		end else begin
			dbg_ent_q <= por_end || reinit;
		end
	end
	assign init_line_n_o  = 1'b0;
	assign init_line_n_oe = por_q;
	assign core_init      = por_q || ilow_sat;
	assign debug_entry    = dbg_ent_q;
	// ****************************************
	// Register decode
	// ****************************************
	logic        sel_ctrl;  // Control register.
	logic        sel_ldlo;  // Load pointer low.
	logic        sel_ldhi;  // Load pointer high.
	logic        sel_lddat; // Load data.
	logic        sel_stat;  // Status register.
	logic        sel_save;  // Saved state area.
	logic [3:0]  reg_idx;   // Saved state index.
	logic        go_wr;     // Software starts RUN.
	logic        clr_wr;    // Software clears reserved flag.
	assign sel_ctrl  = reg_addr == `DCBI_REG_CTRL;
	assign sel_ldlo  = reg_addr == `DCBI_REG_LDLO;
	assign sel_ldhi  = reg_addr == `DCBI_REG_LDHI;
	assign sel_lddat = reg_addr == `DCBI_REG_LDDAT;
	assign sel_stat  = reg_addr == `DCBI_REG_STAT;
	assign sel_save  = reg_addr >= `DCBI_SAVE_LO && reg_addr <= `DCBI_SAVE_HI;
	assign reg_idx   = 4'(reg_addr - `DCBI_SAVE_LO);
	assign go_wr     = reg_wr && sel_ctrl && reg_wdata[`DCBI_CTRL_GO];
	assign clr_wr    = reg_wr && sel_ctrl && reg_wdata[`DCBI_CTRL_CLR];
	// ****************************************
	// Cycle selection
	// ****************************************
	dcbi_state_t st_q;      // Sequencer state.
	dcbi_state_t st_d;      // Next state.
	dcbi_cyc_t   cyc_q;     // Cycle in progress.
	dcbi_cyc_t   nxt_cyc;   // Cycle about to start.
	logic        debug_q;   // Mode, high in DEBUG.
	logic        src_ld_q;  // Cycle belongs to the loader.
	logic [15:0] ld_ptr_q;  // Next load address.
	logic [7:0]  ld_dat_q;  // Byte waiting to load.
	logic        ld_pend_q; // Load byte pending.
	logic        pick_ld;   // Loader wins this start.
	logic        start;     // A cycle starts now.
	logic        nxt_save;  // Next cycle hits saved state.
	logic        ld_take;   // Loader cycle accepted.
	logic        rsv_hit_q; // RUN touched the reserved range.
	logic        rsv_set;   // Reserved range touched now.
	logic        halt_stop; // Halt ends RUN.
	// The loader only runs in DEBUG, ahead of core requests.
	assign pick_ld  = ld_pend_q && debug_q;
	assign start    = st_q == ST_IDLE && (pick_ld || core_req) && !core_init;
	assign ld_take  = start && pick_ld;
	// Loaded bytes keep their value; only the pointer advances.
	assign nxt_cyc  = pick_ld ? dcbi_cyc_t'{addr: ld_ptr_q, wdata: ld_dat_q,
	                             read: 1'b0, opcode_fetch_flag: 1'b0,
	                             delay: 1'b0, halt: 1'b0} : core_cyc;
	// In DEBUG the save area answers from local storage.
	assign nxt_save = debug_q && nxt_cyc.addr >= `DCBI_SAVE_LO &&
	                  nxt_cyc.addr <= `DCBI_SAVE_HI;
	// Application code must stay out of the range kept for debug.
	assign rsv_set  = start && !debug_q && nxt_cyc.addr >= `DCBI_RSV_LO &&
	                  nxt_cyc.addr <= `DCBI_RSV_HI;
	assign halt_stop = start && !debug_q && nxt_cyc.halt && hsel_s;
	// Init and halt win over a software start in the same cycle.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			debug_q <= 1'b1;
		end else if (por_q || reinit || halt_stop) begin
			debug_q <= 1'b1;
		end else if (go_wr) begin
			debug_q <= 1'b0;
		end
	end
	// Sticky flag; a set in the clearing cycle is kept.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rsv_hit_q <= 1'b0;
		end else begin
			rsv_hit_q <= rsv_set || (rsv_hit_q && !clr_wr);
		end
	end
	// Pointer and data are frozen while a byte is pending.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ld_ptr_q  <= 16'h0000;
			ld_dat_q  <= 8'h00;
			ld_pend_q <= 1'b0;
		end else if (reinit) begin
			ld_pend_q <= 1'b0;
		end else if (ld_take) begin
			ld_pend_q <= 1'b0;
			ld_ptr_q  <= ld_ptr_q + 16'h0001;
		end else if (reg_wr && !ld_pend_q) begin
			if (sel_ldlo) ld_ptr_q[7:0] <= reg_wdata;
			if (sel_ldhi) ld_ptr_q[15:8] <= reg_wdata;
			if (sel_lddat) begin
				ld_dat_q  <= reg_wdata;
				ld_pend_q <= 1'b1;
			end
		end
	end
	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	logic [3:0] cnt_q;    // Interval counter.
	logic [3:0] cnt_d;    // Next count.
	logic       int_busy; // Register port owns the store.
	logic [7:0] dout_q;   // Data line output byte.
	logic [7:0] rdata_q;  // Captured read byte.
	logic       int_q;    // Cycle served locally.
	assign int_busy = reg_wr || reg_rd;
	// Strobes stretch while the synchronised wait line is low.
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_IDLE: begin
				cnt_d = 4'h0;
				if (start) st_d = nxt_save ? ST_INT : ST_ADDR;
			end
			ST_ADDR: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == 4'(`DCBI_ADDR_CYC - 1)) begin
					st_d  = ST_DATA;
					cnt_d = 4'h0;
				end
			end
			ST_DATA: begin
				if (cnt_q < 4'(`DCBI_STRB_CYC - 1)) cnt_d = cnt_q + 4'h1;
				if (cnt_q == 4'(`DCBI_STRB_CYC - 1) && wait_s) st_d = ST_DONE;
			end
			ST_INT: begin
				if (!int_busy) st_d = ST_DONE;
			end
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
		if (reinit) st_d = ST_IDLE;
	end
	// Status byte goes out at start, write byte at the data interval.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st_q     <= ST_IDLE;
			cnt_q    <= 4'h0;
			cyc_q    <= '0;
			src_ld_q <= 1'b0;
			int_q    <= 1'b0;
			dout_q   <= 8'h00;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			if (start) begin
				cyc_q    <= nxt_cyc;
				src_ld_q <= pick_ld;
				int_q    <= nxt_save;
				dout_q   <= {nxt_cyc.halt, nxt_cyc.delay,
				             nxt_cyc.opcode_fetch_flag, nxt_cyc.read,
				             nxt_cyc.addr[15:12]};
			end else if (st_q == ST_ADDR && st_d == ST_DATA) begin
				dout_q <= cyc_q.wdata;
			end
		end
	end
	// Read byte is taken on the last strobe clock.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rdata_q <= 8'h00;
		end else if (st_q == ST_DATA && st_d == ST_DONE && cyc_q.read) begin
			rdata_q <= data_s;
		end
	end
	assign address_strobe_n     = !(st_q == ST_ADDR);
	assign read_strobe_n        = !(st_q == ST_DATA && cyc_q.read);
	assign write_strobe_n       = !(st_q == ST_DATA && !cyc_q.read);
	assign shared_data_lines_oe = st_q == ST_ADDR ||
	                              (st_q == ST_DATA && !cyc_q.read);
	assign shared_data_lines_o  = dout_q;
	assign address_lines_o      = cyc_q.addr;
	// Enable low leaves the lines free for forced addresses.
	assign address_lines_oe     = (st_q == ST_ADDR || st_q == ST_DATA) && aden_s;
	assign cycle_request_out    = st_q == ST_ADDR || st_q == ST_DATA;
	assign core_done            = st_q == ST_DONE && !src_ld_q;
	assign debug_mode           = debug_q;
	// ****************************************
	// Saved state store and register reads
	// ****************************************
	logic       mem_we;    // Store write.
	logic [3:0] mem_widx;  // Store write index.
	logic [7:0] mem_wdat;  // Store write byte.
	logic [3:0] mem_ridx;  // Store read index.
	logic [7:0] mem_rdat;  // Store read byte.
	logic       int_wr;    // Core writes saved state.
	logic [3:0] cyc_idx;   // Core index into the store.
	logic [7:0] reg_rdq;   // Register read byte.
	logic       rd_save_q; // Last read hit the store.
	assign cyc_idx  = 4'(cyc_q.addr - `DCBI_SAVE_LO);
	assign int_wr   = st_q == ST_INT && !int_busy && !cyc_q.read;
	// Software writes reach the state restored on resume.
	assign mem_we   = (reg_wr && sel_save) || int_wr;
	assign mem_widx = reg_wr ? reg_idx : cyc_idx;
	assign mem_wdat = reg_wr ? reg_wdata : cyc_q.wdata;
	assign mem_ridx = reg_rd ? reg_idx : cyc_idx;
	dcbi_state_mem u_mem (
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_idx  (mem_widx),
		.wr_data (mem_wdat),
		.rd_idx  (mem_ridx),
		.rd_data (mem_rdat)
	);
	// Unmapped addresses read as zero.
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			reg_rdq   <= 8'h00;
			rd_save_q <= 1'b0;
		end else if (reg_rd) begin
			rd_save_q <= sel_save;
			reg_rdq   <= sel_ldlo  ? ld_ptr_q[7:0] :
			             sel_ldhi  ? ld_ptr_q[15:8] :
			             sel_lddat ? ld_dat_q :
			             sel_stat  ? {4'h0, core_init, rsv_hit_q, ld_pend_q, debug_q} :
			             8'h00;
		end
	end
	assign reg_rdata  = rd_save_q ? mem_rdat : reg_rdq;
	assign core_rdata = int_q ? mem_rdat : rdata_q;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_s_n);
	rsv_flag_a: assert property (rsv_set |=> rsv_hit_q)
		else $error("reserved range access not flagged");
	mode_serve_a: assert property (start && !debug_q && !reinit |=> st_q == ST_ADDR)
		else $error("run cycle not sent to the bus");
	save_rw_a: assert property (reg_wr && sel_save ##1 !reg_wr ##1 reg_rd && !reg_wr &&
		reg_addr == $past(reg_addr, 2) && st_q != ST_INT && $past(st_q) != ST_INT |=>
		reg_rdata == $past(reg_wdata, 3))
		else $error("saved state byte not kept");
	load_step_a: assert property (ld_take && !reinit |=>
		ld_ptr_q == $past(ld_ptr_q) + 16'h0001
		&& cyc_q.wdata == $past(ld_dat_q))
		else $error("load not contiguous");
	wait_hold_a: assert property (st_q == ST_DATA && !wait_s && !reinit |=>
		!read_strobe_n ||
		!write_strobe_n)
		else $error("strobe released while wait low");
	por_pulse_a: assert property (por_q |-> init_line_n_oe && debug_q && !start)
		else $error("power-on pulse wrong");
	reinit_mode_a: assert property (reinit |=> debug_q && st_q == ST_IDLE ##0 debug_entry)
		else $error("reinit did not enter debug");
	addr_float_a: assert property (!aden_s |-> !address_lines_oe)
		else $error("address driven while disabled");
	data_float_a: assert property (shared_data_lines_oe |-> !address_strobe_n ||
		!write_strobe_n)
		else $error("data driven outside strobes");
	addr_status_a: assert property (st_q == ST_IDLE && start && !nxt_save |=>
		shared_data_lines_o == {$past(nxt_cyc.halt), $past(nxt_cyc.delay),
		$past(nxt_cyc.opcode_fetch_flag), $past(nxt_cyc.read), $past(nxt_cyc.addr[15:12])})
		else $error("address strobe byte wrong");
	req_hold_a: assert property (disable iff (!rst_s_n || reinit)
		$rose(cycle_request_out) |-> cycle_request_out[*3])
		else $error("request dropped early");
	cv_stretch: cover property (st_q == ST_DATA && !wait_s ##1 st_q == ST_DONE);
	cv_reinit: cover property (reinit);
	cv_load: cover property (ld_take);
	cv_halt: cover property (halt_stop);
endmodule

// >>> dcbi_mem_model.sv
// Purpose: Application memory responder on the far side of the card bus.
// Assumes: Strobes are active low; the bench sets the read byte and the stall.
// Notes:   Released data lines show a pattern that changes every clock.
`timescale 1ns/1ps
module dcbi_mem_model (
	input  wire logic       clk,      // Clock.
	input  wire logic       as_n,     // Address strobe.
	input  wire logic       ds_n,     // Either data strobe.
	input  wire logic [7:0] dout,     // Card data out.
	input  wire logic [7:0] rbyte,    // Byte answered to reads.
	input  wire logic [3:0] stall,    // Wait clocks per strobe.
	output logic      [7:0] stat_q,   // Status byte seen at address time.
	output logic      [7:0] din,      // Data lines driven back.
	output logic            wait_line // Wait line, pulled high.
);
	logic [3:0] cnt_q = 4'h0;  // Wait clocks still owed.
	logic [7:0] pat_q = 8'hA5; // Junk pattern; starts defined so it never reads unknown.
	// Latch status at address time and count the stall down during the strobe.
	always_ff @(posedge clk) begin
		if (!as_n) stat_q <= dout;
		cnt_q <= !as_n ? stall : (cnt_q != 0 && !ds_n) ? cnt_q - 4'h1 : cnt_q;
		pat_q <= pat_q + 8'h5B;
	end
	// A released bus must not look like the last byte, or a lagging sample passes.
	assign din = !ds_n ? rbyte : pat_q;
	assign wait_line = !(cnt_q != 0 && !ds_n);
endmodule

// >>> tb_debug_card_bus_interface.sv
// Purpose: Self-checking bench for the processor card bus interface.
// Assumes: One 100 MHz clock; the memory model answers the data strobes.
// Notes:   Counts are fixed in the design, so the run is under two thousand clocks.
`timescale 1ns/1ps
module tb_debug_card_bus_interface import dcbi_pkg::*;;
	logic clk, rst_n, core_req, core_done, core_init, debug_entry, reg_wr, reg_rd;
	logic address_lines_oe, address_drive_enable, address_strobe_n, read_strobe_n;
	logic write_strobe_n, shared_data_lines_oe, memory_wait_line, init_line_n_i;
	logic init_line_n_o, init_line_n_oe, cycle_request_out, halt_stop_select;
	logic debug_mode, ext_init_n;
	logic [15:0] reg_addr, address_lines_o;
	logic [7:0] reg_wdata, reg_rdata, core_rdata, shared_data_lines_i, shared_data_lines_o;
	logic [7:0] din, rbyte, stat, d;
	logic [3:0] stall;
	dcbi_cyc_t core_cyc;
	int bad_count, checks_done, len, aok;
	// The board resolves the shared data lines and the open-drain init line.
	assign shared_data_lines_i = shared_data_lines_oe ? shared_data_lines_o : din;
	assign init_line_n_i = ext_init_n & !init_line_n_oe;
	dcbi_top i_dcbi_top (.*);
	dcbi_mem_model i_dcbi_mem_model (.clk(clk), .as_n(address_strobe_n),
		.ds_n(read_strobe_n & write_strobe_n), .dout(shared_data_lines_o), .rbyte(rbyte),
		.stall(stall), .stat_q(stat), .din(din), .wait_line(memory_wait_line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Waits for the entry pulse; DEBUG mode must stand with it.
	task wait_entry(input int lim);
		for (int i = 0; i < lim && debug_entry !== 1'b1; i++) @(posedge clk) #1;
		chk(debug_entry === 1'b1 && debug_mode === 1'b1, "no debug entry");
	endtask
	// One core read; counts strobe clocks, checks the address beside them, takes the byte.
	task bus_rd(input logic [15:0] a, input logic h);
		len = 0;
		aok = 0;
		@(posedge clk);
		core_cyc <= '{a, 8'h00, 1'b1, 1'b0, 1'b0, h};
		core_req <= 1'b1;
		for (int i = 0; i < 60 && core_done !== 1'b1; i++) begin
			@(posedge clk) #1;
			len += int'(read_strobe_n === 1'b0);
			aok += int'(read_strobe_n === 1'b0 && cycle_request_out === 1'b1 &&
				address_lines_o === a && address_lines_oe === address_drive_enable);
		end
		d = core_rdata;
		@(posedge clk);
		core_req <= 1'b0;
	endtask
	task t_saved();
		wr(16'h77FD, 8'h5A);
		rd(16'h77FD, d);
		chk(d === 8'h5A, "saved accumulator");
		wr(16'h77F6, 8'h12);
		rd(16'h77F6, d);
		chk(d === 8'h12, "saved counter high");
	endtask
	task t_run();
		wr(16'h77F0, 8'h01);
		#1 chk(debug_mode === 1'b0, "not in run");
		bus_rd(16'hA123, 1'b0);
		chk(d === 8'hC3 && len == 3 && aok == len, "plain read");
		chk(stat === 8'h1A, "status byte");
		stall <= 4'h4;
		bus_rd(16'h7005, 1'b0);
		chk(d === 8'hC3 && len >= 6, "stretched read");
		rd(16'h77F4, d);
		chk(d[2] === 1'b1, "reserved hit");
	endtask
	task t_reinit();
		ext_init_n <= 1'b0;
		wait_entry(900);
		chk(core_init === 1'b1, "core not held in init");
		ext_init_n <= 1'b1;
	endtask
	// Loader write in DEBUG, then a read with the address drive taken away.
	task t_load();
		wr(16'h77F1, 8'h34);
		wr(16'h77F2, 8'h12);
		wr(16'h77F3, 8'hA7);
		for (int i = 0; i < 20 && write_strobe_n !== 1'b0; i++) @(posedge clk) #1;
		chk(shared_data_lines_o === 8'hA7 && address_lines_o === 16'h1234, "load byte");
		rd(16'h77F1, d);
		chk(d === 8'h35, "load pointer step");
		address_drive_enable <= 1'b0;
		bus_rd(16'h7100, 1'b0);
		chk(d === 8'hC3 && aok == len && len > 0, "forced address cycle");
		address_drive_enable <= 1'b1;
	endtask
	// Halt status with the debug select ends RUN.
	task t_halt();
		halt_stop_select <= 1'b1;
		wr(16'h77F0, 8'h01);
		bus_rd(16'h8001, 1'b1);
		chk(debug_mode === 1'b1 && stat === 8'h98 && aok == len, "halt stop");
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{rst_n, core_req, reg_wr, reg_rd, halt_stop_select, stall} = '0;
		{core_cyc, reg_addr, reg_wdata} = '0;
		{address_drive_enable, ext_init_n, rbyte} = {2'b11, 8'hC3};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wait_entry(700);
		chk(init_line_n_oe === 1'b0 && core_init === 1'b0, "init pulse not ended");
		t_saved();
		t_run();
		t_reinit();
		t_load();
		t_halt();
		give_verdict();
	end
	// Cuts a hang short at ten thousand clocks, well past the expected run of under two thousand.
	initial begin
		#100000;
		bad_count++;
		give_verdict();
	end
endmodule
